// [hdl/spi_err_wake_consts.svh]
// Constants for the serial port error, flag and wake-up block.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef SPI_ERR_WAKE_CONSTS_SVH
`define SPI_ERR_WAKE_CONSTS_SVH

// Control register fields
`define CR_IRQ_EN 7
`define CR_OUT_EN 6
`define CR_DIV2 5
`define CR_MASTER 4
`define CR_CPOL 3
`define CR_CPHA 2
`define CR_RESET 8'h00

// Control/status register fields
`define CSR_TC 7
`define CSR_WRITE_COLLISION_FLAG 6
`define CSR_OVR 5
`define CSR_MODE_FAULT_FLAG 4
`define CSR_SPARE 3
`define CSR_SOD 2
`define CSR_SSM 1
`define CSR_SSI 0
`define CSR_RESET 8'h00

`define BYTE_BITS 4'h8
`define DATA_RESET 8'h00

// Master serial clock half period
`define CORE_PERIOD_NS 10
`define SCK_HALF_NS 40
`define SCK_HALF_CYC ((`SCK_HALF_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)

`endif

// [hdl/spi_err_wake_pkg.sv]
// Types for the serial port error, flag and wake-up block.
// No dependencies.
package spi_err_wake_pkg;
    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_LEAD = 2'b01,
        M_TRAIL = 2'b11
    } master_state_t;
endpackage : spi_err_wake_pkg

// [hdl/spi_link_slave.sv]
// Slave shifter running on the link clock from the remote master.
// Assumes clock mode 0 and a transmit byte held stable while selected.
`timescale 1ns/1ps
`default_nettype none
module spi_link_slave (
    input wire logic sck,
    input wire logic resetn,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte,
    output logic done_tgl
);
    logic [2:0] cnt;
    logic [6:0] rx_sh;
    logic [7:0] tx_sh;
    logic sel_rst_n;

    // Deselect restarts the bit count, so a partial byte is dropped
    assign sel_rst_n = resetn & ~sel_n;

    always_ff @(posedge sck or negedge sel_rst_n) begin
        if (!sel_rst_n) begin
            cnt <= 3'h0;
            rx_sh <= 7'h00;
        end else begin
            cnt <= cnt + 3'h1;
            rx_sh <= {rx_sh[5:0], mosi};
        end
    end

    // Byte and toggle survive deselect; core reads them after the toggle
    always_ff @(posedge sck or negedge resetn) begin
        if (!resetn) begin
            rx_byte <= 8'h00;
            done_tgl <= 1'b0;
        end else if (!sel_n && cnt == 3'h7) begin
            rx_byte <= {rx_sh, mosi};
            done_tgl <= ~done_tgl;
        end
    end

    always_ff @(negedge sck or negedge sel_rst_n) begin
        if (!sel_rst_n) begin
            tx_sh <= 8'h00;
        end else if (cnt == 3'h1) begin
            tx_sh <= {tx_byte[6:0], 1'b0};
        end else begin
            tx_sh <= {tx_sh[6:0], 1'b0};
        end
    end

    assign miso = (cnt == 3'h0) ? tx_byte[7] : tx_sh[7];
endmodule : spi_link_slave
`default_nettype wire

// [hdl/spi_err_wake.sv]
// Serial port error flags, status clearing, interrupt and wake-up logic.
// Assumes software strobes are single-cycle pulses on core_clk and that
// the remote master clocks the link in mode 0 while selecting us.
`timescale 1ns/1ps
`default_nettype none
`include "spi_err_wake_consts.svh"
module spi_err_wake (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic csr_wr,
    input wire logic [7:0] csr_wdata,
    input wire logic csr_rd,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    input wire logic data_rd,
    output logic [7:0] ctrl_rdata,
    output logic [7:0] csr_rdata,
    output logic [7:0] data_rdata,
    input wire logic cpu_int_mask,
    input wire logic wait_mode,
    input wire logic halt_mode,
    output logic irq,
    output logic wakeup,
    input wire logic sck_link,
    output logic sck_out,
    output logic sck_oe_n,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_n,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_n,
    input wire logic ss_n_in
);
    // Control register bits
    logic port_irq_enable;
    logic port_output_enable;
    logic div2_disable;
    logic master_select;
    logic clk_polarity;
    logic clk_phase;
    logic [1:0] rate_sel;

    // Control/status register bits
    logic transfer_complete_flag;
    logic write_collision_flag;
    logic overrun_flag;
    logic mode_fault_flag;
    logic spare_bit;
    logic slave_out_disable;
    logic soft_select_mode;
    logic soft_select_level;

    // Clearing sequence progress
    logic tc_armed;
    logic mode_fault_flag_armed;
    logic write_collision_flag_armed;

    // Synchronisers
    logic ss_meta;
    logic ss_sync;
    logic miso_meta;
    logic miso_sync;
    logic done_meta;
    logic done_sync;
    logic done_seen;

    // Halt tracking
    logic halt_seen;
    logic halt_wake_ok;

    // Transmit byte and master engine
    logic [7:0] tx_byte;
    logic [7:0] m_shift;
    logic [7:0] m_rx;
    logic [3:0] m_bits;
    logic [3:0] m_div;
    spi_err_wake_pkg::master_state_t m_state;
    spi_err_wake_pkg::master_state_t next_m_state;

    // Link side
    logic link_miso;
    logic [7:0] link_rx;
    logic link_done_tgl;

    // Gated strobes and events
    logic live;
    logic ctrl_wr_g;
    logic csr_wr_g;
    logic csr_rd_g;
    logic data_wr_g;
    logic data_rd_g;
    logic ss_int_n;
    logic mode_fault_flag_event;
    logic slave_rx_en;
    logic slave_done;
    logic master_done;
    logic byte_done;
    logic [7:0] byte_in;
    logic busy;
    logic data_wr_ok;
    logic write_collision_flag_event;
    logic flag_any;

    // Software sees a frozen port in halt
    assign live = ~halt_mode;
    assign ctrl_wr_g = ctrl_wr & live;
    assign csr_wr_g = csr_wr & live;
    assign csr_rd_g = csr_rd & live;
    assign data_wr_g = data_wr & live;
    assign data_rd_g = data_rd & live;

    // Pin and link event synchronisers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ss_meta <= 1'b1;
            ss_sync <= 1'b1;
            miso_meta <= 1'b0;
            miso_sync <= 1'b0;
        end else begin
            ss_meta <= ss_n_in;
            ss_sync <= ss_meta;
            miso_meta <= miso_in;
            miso_sync <= miso_meta;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            done_meta <= 1'b0;
            done_sync <= 1'b0;
            done_seen <= 1'b0;
        end else begin
            done_meta <= link_done_tgl;
            done_sync <= done_meta;
            done_seen <= done_sync;
        end
    end

    assign ss_int_n = soft_select_mode ? soft_select_level : ss_sync;
    assign mode_fault_flag_event = master_select & port_output_enable & ~ss_int_n
        & live;

    // Slave bytes still arrive in halt when wake-up is armed
    assign slave_rx_en = port_output_enable & ~master_select
        & (live | halt_wake_ok);
    assign slave_done = (done_sync ^ done_seen) & slave_rx_en;
    assign master_done = (m_state == spi_err_wake_pkg::M_TRAIL) & live
        & (m_div == 4'h0) & (m_bits == `BYTE_BITS - 4'h1);
    assign byte_done = slave_done | master_done;
    assign byte_in = master_select ? m_rx : link_rx;

    // Slave counts as busy for the whole time it is selected
    assign busy = master_select ? (m_state != spi_err_wake_pkg::M_IDLE)
        : (port_output_enable & ~ss_int_n);
    assign write_collision_flag_event = data_wr_g & busy;
    assign data_wr_ok = data_wr_g & ~busy
        & ~(transfer_complete_flag & ~tc_armed);

    // Control register; hardware fault takes priority over software
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            port_irq_enable <= 1'(`CR_RESET >> `CR_IRQ_EN);
            port_output_enable <= 1'b0;
            div2_disable <= 1'b0;
            master_select <= 1'b0;
            clk_polarity <= 1'b0;
            clk_phase <= 1'b0;
            rate_sel <= 2'h0;
        end else if (mode_fault_flag_event) begin
            port_output_enable <= 1'b0;
            master_select <= 1'b0;
        end else if (ctrl_wr_g) begin
            port_irq_enable <= ctrl_wdata[`CR_IRQ_EN];
            port_output_enable <= ctrl_wdata[`CR_OUT_EN]
                & (~mode_fault_flag | mode_fault_flag_armed);
            div2_disable <= ctrl_wdata[`CR_DIV2];
            master_select <= ctrl_wdata[`CR_MASTER]
                & (~mode_fault_flag | mode_fault_flag_armed);
            clk_polarity <= ctrl_wdata[`CR_CPOL];
            clk_phase <= ctrl_wdata[`CR_CPHA];
            rate_sel <= ctrl_wdata[1:0];
        end
    end

    // Software configuration half of the status register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            spare_bit <= 1'b0;
            slave_out_disable <= 1'b0;
            soft_select_mode <= 1'b0;
            soft_select_level <= 1'b0;
        end else if (csr_wr_g) begin
            spare_bit <= csr_wdata[`CSR_SPARE];
            slave_out_disable <= csr_wdata[`CSR_SOD];
            soft_select_mode <= csr_wdata[`CSR_SSM];
            soft_select_level <= csr_wdata[`CSR_SSI];
        end
    end

    // Mode fault flag and its read-then-write clearing sequence
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_fault_flag <= 1'b0;
            mode_fault_flag_armed <= 1'b0;
        end else if (mode_fault_flag_event) begin
            mode_fault_flag <= 1'b1;
        end else if (ctrl_wr_g) begin
            if (mode_fault_flag_armed) begin
                mode_fault_flag <= 1'b0;
            end
            mode_fault_flag_armed <= 1'b0;
        end else if (csr_rd_g && mode_fault_flag) begin
            mode_fault_flag_armed <= 1'b1;
        end
    end

    // Transfer complete flag; set wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            transfer_complete_flag <= 1'b0;
            tc_armed <= 1'b0;
        end else if (byte_done) begin
            transfer_complete_flag <= 1'b1;
        end else if (tc_armed && (data_rd_g || data_wr_g)) begin
            transfer_complete_flag <= 1'b0;
            tc_armed <= 1'b0;
        end else if (csr_rd_g && transfer_complete_flag) begin
            tc_armed <= 1'b1;
        end
    end

    // Overrun: a second byte before the complete flag is cleared
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            overrun_flag <= 1'b0;
        end else if (byte_done && transfer_complete_flag) begin
            overrun_flag <= 1'b1;
        end else if (csr_rd_g) begin
            overrun_flag <= 1'b0;
        end
    end

    // Write collision: data writes never clear it, data reads may
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            write_collision_flag <= 1'b0;
            write_collision_flag_armed <= 1'b0;
        end else if (write_collision_flag_event) begin
            write_collision_flag <= 1'b1;
        end else if (write_collision_flag_armed && data_rd_g) begin
            write_collision_flag <= 1'b0;
            write_collision_flag_armed <= 1'b0;
        end else if (csr_rd_g && write_collision_flag) begin
            write_collision_flag_armed <= 1'b1;
        end
    end

    // Receive buffer holds only the first byte after the flag clears
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            data_rdata <= `DATA_RESET;
        end else if (byte_done && !transfer_complete_flag) begin
            data_rdata <= byte_in;
        end
    end

    // Transmit byte; a slave left unwritten echoes what it received
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tx_byte <= `DATA_RESET;
        end else if (data_wr_ok) begin
            tx_byte <= data_wdata;
        end else if (slave_done) begin
            tx_byte <= link_rx;
        end
    end

    // Select level caught as halt begins decides halt wake-up
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            halt_seen <= 1'b0;
            halt_wake_ok <= 1'b0;
        end else begin
            halt_seen <= halt_mode;
            if (halt_mode && !halt_seen) begin
                halt_wake_ok <= ~ss_int_n;
            end else if (!halt_mode) begin
                halt_wake_ok <= 1'b0;
            end
        end
    end

    // Master engine: phase 0 timing, polarity from clk_polarity, divider fixed, frozen in halt
    always_comb begin
        next_m_state = m_state;
        case (m_state)
            spi_err_wake_pkg::M_IDLE: begin
                if (data_wr_ok && master_select && port_output_enable) begin
                    next_m_state = spi_err_wake_pkg::M_LEAD;
                end
            end
            spi_err_wake_pkg::M_LEAD: begin
                if (m_div == 4'h0) begin
                    next_m_state = spi_err_wake_pkg::M_TRAIL;
                end
            end
            spi_err_wake_pkg::M_TRAIL: begin
                if (m_div == 4'h0) begin
                    if (m_bits == `BYTE_BITS - 4'h1) begin
                        next_m_state = spi_err_wake_pkg::M_IDLE;
                    end else begin
                        next_m_state = spi_err_wake_pkg::M_LEAD;
                    end
                end
            end
            default: next_m_state = spi_err_wake_pkg::M_IDLE;
        endcase
        if (!master_select || !port_output_enable) begin
            next_m_state = spi_err_wake_pkg::M_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            m_state <= spi_err_wake_pkg::M_IDLE;
        end else if (live) begin
            m_state <= next_m_state;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            m_div <= 4'h0;
            m_bits <= 4'h0;
            m_shift <= 8'h00;
            m_rx <= 8'h00;
        end else if (live) begin
            if (m_state == spi_err_wake_pkg::M_IDLE) begin
                m_div <= 4'(`SCK_HALF_CYC - 1);
                m_bits <= 4'h0;
                if (data_wr_ok) begin
                    m_shift <= data_wdata;
                end
            end else if (m_div != 4'h0) begin
                m_div <= m_div - 4'h1;
            end else begin
                m_div <= 4'(`SCK_HALF_CYC - 1);
                if (m_state == spi_err_wake_pkg::M_LEAD) begin
                    m_rx <= {m_rx[6:0], miso_sync};
                end else begin
                    m_shift <= {m_shift[6:0], 1'b0};
                    m_bits <= m_bits + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sck_out <= 1'b0;
        end else begin
            sck_out <= clk_polarity
                ^ (next_m_state == spi_err_wake_pkg::M_TRAIL);
        end
    end

    spi_link_slave link (
        .sck(sck_link),
        .resetn(resetn),
        .sel_n(ss_int_n | master_select),
        .mosi(mosi_in),
        .tx_byte(tx_byte),
        .miso(link_miso),
        .rx_byte(link_rx),
        .done_tgl(link_done_tgl)
    );

    // Pins released whenever the port is disabled
    assign sck_oe_n = ~(port_output_enable & master_select);
    assign mosi_oe_n = ~(port_output_enable & master_select);
    assign mosi_out = m_shift[7];
    assign miso_out = link_miso;
    assign miso_oe_n = ~(port_output_enable & ~master_select & ~ss_int_n
        & ~slave_out_disable);

    // One request line; collision is deliberately left out
    assign flag_any = transfer_complete_flag | mode_fault_flag
        | overrun_flag;
    assign irq = port_irq_enable & ~cpu_int_mask & flag_any;

    // Wait wakes on any enabled interrupt request, halt only on a completed byte
    assign wakeup = (wait_mode & irq)
        | (halt_mode & halt_wake_ok & port_irq_enable & ~cpu_int_mask
        & transfer_complete_flag);

    assign ctrl_rdata = {port_irq_enable, port_output_enable, div2_disable,
        master_select, clk_polarity, clk_phase, rate_sel};
    assign csr_rdata = {transfer_complete_flag, write_collision_flag,
        overrun_flag, mode_fault_flag, spare_bit, slave_out_disable,
        soft_select_mode, soft_select_level};
endmodule : spi_err_wake
`default_nettype wire

// [testbench/spi_err_wake_props.sv]
// Port checks for the serial port error flag and wake-up block.
// Bound to spi_err_wake below; single core clock domain.
`timescale 1ns/1ps
`default_nettype none
module spi_err_wake_props (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic csr_rd,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] ctrl_rdata,
    input wire logic [7:0] csr_rdata,
    input wire logic cpu_int_mask,
    input wire logic wait_mode,
    input wire logic halt_mode,
    input wire logic irq,
    input wire logic wakeup,
    input wire logic ss_n_in
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic armed;
    // Status read seen while the fault flag shows
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            armed <= 1'b0;
        end else if (!csr_rdata[4]) begin
            armed <= 1'b0;
        end else if (csr_rd) begin
            armed <= 1'b1;
        end
    end
    chk_irq_gating: assert property (
        !halt_mode |-> irq == (ctrl_rdata[7] && !cpu_int_mask
        && (csr_rdata[7] || csr_rdata[5] || csr_rdata[4])))
        else $error("irq differs from flags and enables");
    chk_write_collision_flag_quiet: assert property (
        csr_rdata[6] && !csr_rdata[7] && !csr_rdata[5] && !csr_rdata[4]
        |-> !irq) else $error("collision flag raised irq");
    // Master drops within three samples of a low pin, so two is the span
    chk_fault_sets: assert property (
        (ctrl_rdata[4] && ctrl_rdata[6] && !ss_n_in && !halt_mode
        && !csr_rdata[1])[*2] |-> ##[0:3] csr_rdata[4])
        else $error("no mode fault");
    chk_fault_drops: assert property (
        $rose(csr_rdata[4]) |-> ##[0:1] !(ctrl_rdata[6] || ctrl_rdata[4]))
        else $error("enable or master kept on fault");
    chk_fault_refuse: assert property (
        csr_rdata[4] && !armed && !csr_rd && !ctrl_rdata[6]
        |=> !ctrl_rdata[6]) else $error("enable set while fault");
    chk_fault_clear: assert property (
        $fell(csr_rdata[4]) |-> $past(armed))
        else $error("fault cleared without status read");
    chk_ovr_clear: assert property (
        csr_rd && csr_rdata[5] && !halt_mode |-> ##[1:2] !csr_rdata[5])
        else $error("overrun kept");
    chk_write_collision_flag_hold: assert property (
        (!data_rd)[*2] ##1 (csr_rdata[6] && data_wr && !data_rd)
        |=> csr_rdata[6]) else $error("data write cleared collision");
    chk_halt_wake: assert property (
        halt_mode && wakeup |-> ##[0:2] csr_rdata[7])
        else $error("halt wake without complete");
    chk_wait_wake: assert property (wait_mode && irq |-> wakeup)
        else $error("wait not woken");
endmodule : spi_err_wake_props
bind spi_err_wake spi_err_wake_props chk (
    .core_clk(core_clk), .resetn(resetn), .csr_rd(csr_rd),
    .data_wr(data_wr), .data_rd(data_rd), .ctrl_rdata(ctrl_rdata),
    .csr_rdata(csr_rdata), .cpu_int_mask(cpu_int_mask),
    .wait_mode(wait_mode), .halt_mode(halt_mode), .irq(irq),
    .wakeup(wakeup), .ss_n_in(ss_n_in)
);
`default_nettype wire

// [testbench/spi_far_master.sv]
// Remote link master model: mode 0, msb first, 48 ns link clock.
// The bench calls its tasks; clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module spi_far_master (
    output logic sck,
    output logic ss_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end
    // One slave only; held low across halt entry and high while clearing, except in the master test
    task automatic select(input logic lvl);
        ss_n = lvl;
        // Released data line flips so no stale bit passes
        if (lvl) begin
            mosi = ~mosi;
        end
    endtask : select
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        #13;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #24 sck = 1'b1;
            rx[i] = miso;
            #24 sck = 1'b0;
        end
    endtask : xfer
endmodule : spi_far_master
`default_nettype wire

// [testbench/test_spi_err_wake.sv]
// Bench for the serial port error flag and wake-up block.
// Remote master model on the link; bench drives the software side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin \
    comparisons++; \
    if ((a) !== (b)) begin \
        fails++; \
        $display("[FAIL] %0t %s", $time, m); \
    end \
end
module test_spi_err_wake;
    logic core_clk, resetn, ctrl_wr, csr_wr, csr_rd, data_wr, data_rd;
    logic cpu_int_mask, wait_mode, halt_mode, irq, wakeup;
    logic [7:0] ctrl_wdata, data_wdata, ctrl_rdata, csr_rdata, data_rdata;
    logic [7:0] csr_wdata;
    logic [7:0] cap = 8'h00;
    int ncap = 0;
    logic [7:0] rx;
    logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
    logic far_sck, far_ss_n, far_mosi;
    wire sck_line, mosi_line, miso_line;
    int fails = 0;
    int comparisons = 0;
    assign sck_line = sck_oe_n ? far_sck : sck_out;
    assign mosi_line = mosi_oe_n ? far_mosi : mosi_out;
    // Undriven slave output rests high on its pull-up
    assign miso_line = miso_oe_n ? 1'b1 : miso_out;
    spi_err_wake dut (
        .core_clk(core_clk), .resetn(resetn), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .csr_wr(csr_wr), .csr_wdata(csr_wdata),
        .csr_rd(csr_rd), .data_wr(data_wr), .data_wdata(data_wdata),
        .data_rd(data_rd), .ctrl_rdata(ctrl_rdata),
        .csr_rdata(csr_rdata), .data_rdata(data_rdata),
        .cpu_int_mask(cpu_int_mask), .wait_mode(wait_mode),
        .halt_mode(halt_mode), .irq(irq), .wakeup(wakeup),
        .sck_link(sck_line), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
        .mosi_in(mosi_line), .mosi_out(mosi_out),
        .mosi_oe_n(mosi_oe_n), .miso_in(miso_line),
        .miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_n_in(far_ss_n)
    );
    spi_far_master far (
        .sck(far_sck), .ss_n(far_ss_n), .mosi(far_mosi), .miso(miso_line)
    );
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Bits as a remote slave would take them while we drive the clock
    always @(posedge sck_line) begin
        if (!sck_oe_n) begin
            cap <= {cap[6:0], mosi_line};
            ncap <= ncap + 1;
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    // Kinds: 0 control write, 1 status read, 2 data write, 3 data read,
    // 4 status write
    task automatic sw(input int k, input logic [7:0] d);
        @(posedge core_clk);
        ctrl_wr <= (k == 0);
        csr_wr <= (k == 4);
        csr_rd <= (k == 1);
        data_wr <= (k == 2);
        data_rd <= (k == 3);
        ctrl_wdata <= d;
        data_wdata <= d;
        csr_wdata <= d;
        @(posedge core_clk);
        {ctrl_wr, csr_wr, csr_rd, data_wr, data_rd} <= 5'h00;
        cyc(2);
    endtask : sw
    task automatic wait_for(input logic w);
        for (int i = 0; i < 80 && (w ? wakeup : csr_rdata[7]) !== 1'b1; i++)
            cyc(1);
    endtask : wait_for
    task automatic t_slave_rx;
        sw(0, 8'hc0);
        far.select(1'b0);
        far.xfer(8'ha5, rx);
        far.select(1'b1);
        wait_for(1'b0);
        `CHK(data_rdata, 8'ha5, "rx byte")
        `CHK(irq, 1'b1, "complete irq")
        @(posedge core_clk);
        cpu_int_mask <= 1'b1;
        cyc(1);
        `CHK(irq, 1'b0, "masked irq")
        @(posedge core_clk);
        cpu_int_mask <= 1'b0;
        sw(2, 8'h3c);
        sw(1, 8'h00);
        sw(3, 8'h00);
        `CHK(csr_rdata[7], 1'b0, "complete kept")
        far.select(1'b0);
        far.xfer(8'h5a, rx);
        far.select(1'b1);
        `CHK(rx, 8'ha5, "echo byte")
        wait_for(1'b0);
        far.select(1'b0);
        far.xfer(8'h11, rx);
        far.select(1'b1);
        cyc(8);
        `CHK(csr_rdata[5], 1'b1, "no overrun")
        `CHK(data_rdata, 8'h5a, "overrun byte")
        sw(1, 8'h00);
        `CHK(csr_rdata[5], 1'b0, "overrun kept")
        sw(3, 8'h00);
        $display("slave receive test done");
    endtask : t_slave_rx
    task automatic t_write_collision_flag;
        far.select(1'b0);
        cyc(4);
        sw(2, 8'h77);
        `CHK(csr_rdata[6], 1'b1, "no collision")
        `CHK(irq, 1'b0, "collision irq")
        sw(2, 8'h78);
        `CHK(csr_rdata[6], 1'b1, "write cleared collision")
        far.select(1'b1);
        sw(1, 8'h00);
        sw(3, 8'h00);
        `CHK(csr_rdata[6], 1'b0, "collision kept")
        $display("collision test done");
    endtask : t_write_collision_flag
    task automatic t_halt;
        far.select(1'b0);
        cyc(4);
        @(posedge core_clk);
        halt_mode <= 1'b1;
        cyc(2);
        far.xfer(8'h96, rx);
        wait_for(1'b1);
        `CHK(wakeup, 1'b1, "no halt wake")
        far.xfer(8'h69, rx);
        cyc(8);
        sw(1, 8'h00);
        `CHK(csr_rdata[5], 1'b1, "no halt overrun")
        @(posedge core_clk);
        halt_mode <= 1'b0;
        far.select(1'b1);
        cyc(2);
        `CHK(data_rdata, 8'h96, "halt byte")
        sw(1, 8'h00);
        sw(3, 8'h00);
        far.select(1'b0);
        far.xfer(8'h5c, rx);
        far.select(1'b1);
        `CHK(rx, 8'h69, "echo after halt")
        wait_for(1'b0);
        sw(1, 8'h00);
        sw(3, 8'h00);
        $display("halt test done");
    endtask : t_halt
    task automatic t_mode_fault_flag;
        sw(0, 8'hd0);
        `CHK(ctrl_rdata & 8'h50, 8'h50, "master not set")
        @(posedge core_clk);
        wait_mode <= 1'b1;
        far.select(1'b0);
        cyc(8);
        `CHK(csr_rdata[4], 1'b1, "no mode fault")
        `CHK(irq, 1'b1, "no fault irq")
        `CHK(ctrl_rdata & 8'h50, 8'h00, "bits kept")
        `CHK({sck_oe_n, mosi_oe_n}, 2'b11, "pins kept")
        `CHK(wakeup, 1'b1, "no wait wake")
        far.select(1'b1);
        @(posedge core_clk);
        wait_mode <= 1'b0;
        sw(0, 8'hd0);
        `CHK(ctrl_rdata & 8'h50, 8'h00, "set during fault")
        `CHK(csr_rdata[4], 1'b1, "fault cleared early")
        @(posedge core_clk);
        csr_rd <= 1'b1;
        @(posedge core_clk);
        csr_rd <= 1'b0;
        ctrl_wr <= 1'b1;
        @(posedge core_clk);
        ctrl_wr <= 1'b0;
        cyc(2);
        `CHK(csr_rdata[4], 1'b0, "fault kept")
        `CHK(ctrl_rdata & 8'h50, 8'h50, "not restored")
        sw(0, 8'h00);
        $display("mode fault test done");
    endtask : t_mode_fault_flag
    // Soft select high, so the low pin must not fault the master
    task automatic t_master;
        sw(4, 8'h0f);
        `CHK(csr_rdata[3:0], 4'hf, "status bits")
        sw(0, 8'hd0);
        far.select(1'b0);
        sw(2, 8'h3c);
        `CHK({sck_oe_n, mosi_oe_n}, 2'b00, "pins not driven")
        sw(2, 8'h99);
        `CHK(csr_rdata[6], 1'b1, "no master collision")
        wait_for(1'b0);
        `CHK(ncap, 8, "bit count")
        `CHK(cap, 8'h3c, "sent byte")
        `CHK(data_rdata, 8'hff, "master rx byte")
        `CHK(csr_rdata[4], 1'b0, "soft select fault")
        sw(1, 8'h00);
        sw(3, 8'h00);
        `CHK(csr_rdata[7:6], 2'b00, "flags kept")
        sw(0, 8'h00);
        far.select(1'b1);
        sw(4, 8'h00);
        $display("master test done");
    endtask : t_master
    task automatic summarize;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        resetn = 1'b0;
        {ctrl_wr, csr_wr, csr_rd, data_wr, data_rd} = 5'h00;
        csr_wdata = 8'h00;
        {cpu_int_mask, wait_mode, halt_mode} = 3'h0;
        ctrl_wdata = 8'h00;
        data_wdata = 8'h00;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        cyc(3);
        t_slave_rx;
        t_write_collision_flag;
        t_halt;
        t_mode_fault_flag;
        t_master;
        summarize;
    end
    initial begin
        #200000;
        fails++;
        summarize;
    end
endmodule : test_spi_err_wake
`default_nettype wire
